// file: hpm_config.sv
// Hub port map, port counts and SMBus block read/write configuration slave.
// How it works
// R1 - All used, none legacy: four SuperSpeed ports, six USB 2.0, identity mapping.
// R2 - Ports with used and legacy bits clear are skipped; numbering stays consecutive.
// R3 - HID takes the number after the last external port, billboard the next.
// R4 - Used port with removable bit clear is reported permanently attached, by logical number.
// R5 - A legacy-only port is reported on USB 2.0 only and still gets a number.
// R6 - Ports on both hubs are numbered first, legacy-only ports afterwards.
// R7 - Used 1111 with legacy 1110 gives one SuperSpeed and six USB 2.0 ports.
// R8 - Used 1010 with legacy 0x0x blocks Gen 1 speed on physical port 4.
// R9 - Used 1011 with legacy 0x01 blocks Gen 1 speed on physical port 4.
// R10 - Used 1110 with legacy 010x blocks Gen 1 speed on physical port 4.
// R11 - Used 1111 with legacy 0101 blocks Gen 1 speed on physical port 4.
// R12 - Slave only; only block read and block write are supported.
// R13 - Other protocols get no acknowledge from the device.
// R14 - No timeout; upstream stays disconnected until the host clears config-active.
// R15 - Addresses 1000100 and 1000101 reach bytes 000-0FF and 100-1FF.
// R16 - Address 1000110 reaches bytes 200 up to 2DF.
// R17 - Serial port enabled only if both lines high at reset release; strap picks mode.
// R18 - HID is always second-highest USB 2.0 port, billboard the highest.
// R19 - Counts and mapping are frozen from masks when config-active clears.
// R20 - Byte address increments per byte within the addressed slave's range.
`timescale 1ns/100ps
`include "hpm_consts.svh"
module hpm_config import hpm_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        serialClockIn,
  input  wire logic        serialDataIn,
  input  wire logic        hostIfModeStrap,
  output logic             serialDataOut,
  output logic             serialDataOe,
  output logic             upstreamConnectEn,
  output logic             port4NoGen1,
  output logic [2:0]       usb3PortCount,
  output logic [2:0]       usb2PortCount,
  output logic [2:0]       hidPort,
  output logic [2:0]       billboardPort,
  output logic [11:0]      logicalPortMap,
  output logic [3:0]       usb3MemberMask,
  output logic [5:0]       permAttachedMask
);
  // Every assertion below runs on the system clock and rests during reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Slave address to base window; bit 2 flags a match.
  function automatic logic [2:0] slaveBase(input logic [6:0] a);
    unique case (a)
      `HPM_SADDR_BASE0: slaveBase = 3'h4;
      `HPM_SADDR_BASE1: slaveBase = 3'h5;
      `HPM_SADDR_BASE2: slaveBase = 3'h6;
      default:          slaveBase = 3'h0;
    endcase
  endfunction
  // Mask combinations that keep physical port 4 off Gen 1 speed.
  function automatic logic invalidCombo(input logic [3:0] u, input logic [3:0] l);
    invalidCombo = ((u == 4'hA) && !l[3] && !l[1])
                || ((u == 4'hB) && !l[3] && !l[1] && l[0])
                || ((u == 4'hE) && !l[3] && l[2] && !l[1])
                || ((u == 4'hF) && (l == 4'h5));
  endfunction
  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] syncA, syncB;
  logic       sclPrev, sdaPrev;
  // Each pin passes two flip-flops before any logic looks at it.
  for (genvar g = 0; g < 3; g++) begin : gSync
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        syncA[g] <= 1'b1;
        syncB[g] <= 1'b1;
      end else begin
        syncA[g] <= (g == 0) ? serialClockIn : (g == 1) ? serialDataIn : hostIfModeStrap;
        syncB[g] <= syncA[g];
      end
    end
  end
  // Previous samples give clock edges and start/stop conditions.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= syncB[0];
      sdaPrev <= syncB[1];
    end
  end
  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise   = syncB[0] & ~sclPrev;
  assign sclFall   = ~syncB[0] & sclPrev;
  assign startCond = syncB[0] & sclPrev & sdaPrev & ~syncB[1];
  assign stopCond  = syncB[0] & sclPrev & ~sdaPrev & syncB[1];
  // ------------------------------------------------------------
  // State declarations
  // ------------------------------------------------------------
  hpm_state_e  state_reg, state_next;
  hpm_kind_e   kind_reg, kind_next;
  logic [3:0]  bitCnt_reg, bitCnt_next;
  logic [7:0]  shift_reg, shift_next, tx_reg, tx_next, cnt_reg, cnt_next, idx_reg, idx_next;
  logic [9:0]  ptr_reg, ptr_next;
  logic [1:0]  base_reg, base_next, strapCnt_reg, strapCnt_next;
  logic        isRd_reg, isRd_next, cmdSeen_reg, cmdSeen_next, acked_reg, acked_next;
  logic        oe_reg, oe_next, smbus_reg, smbus_next, cfgAct_reg, cfgAct_next;
  logic [3:0]  rmbl_reg, rmbl_next, used_reg, used_next, leg_reg, leg_next;
  logic        wrEn;
  logic [7:0]  rdData;
  logic [7:0]  mem [0:`HPM_MEM_DEPTH-1];
  logic [2:0]  addrHit;
  // Address byte decoded once for the acknowledge and the window base.
  assign addrHit = slaveBase(shift_reg[7:1]);
  // Read data for the byte under the pointer.
  always_comb begin
    rdData = 8'h00;
    if (ptr_reg == `HPM_OFF_RMBL) rdData = {4'h0, rmbl_reg};
    else if (ptr_reg == `HPM_OFF_USED) rdData = {4'h0, used_reg};
    else if (ptr_reg == `HPM_OFF_LEGACY) rdData = {4'h0, leg_reg};
    else if (ptr_reg == `HPM_OFF_STATUS) rdData = {7'h00, cfgAct_reg};
    else if (ptr_reg <= `HPM_RANGE_END) rdData = mem[ptr_reg];
  end
  // ------------------------------------------------------------
  // Strap capture, masks and SMBus slave next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;      kind_next = kind_reg;     bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;      tx_next = tx_reg;         cnt_next = cnt_reg;
    idx_next = idx_reg;          ptr_next = ptr_reg;       base_next = base_reg;
    isRd_next = isRd_reg;        cmdSeen_next = cmdSeen_reg;
    acked_next = acked_reg;      oe_next = oe_reg;         smbus_next = smbus_reg;
    cfgAct_next = cfgAct_reg;    rmbl_next = rmbl_reg;     used_next = used_reg;
    leg_next = leg_reg;          wrEn = 1'b0;
    strapCnt_next = (strapCnt_reg == 2'h3) ? strapCnt_reg : strapCnt_reg + 2'h1;
    // R17 mode strap
    if (strapCnt_reg == `HPM_STRAP_WAIT) begin
      smbus_next = syncB[0] & syncB[1] & ~syncB[2];
      if (!(syncB[0] & syncB[1] & ~syncB[2])) cfgAct_next = 1'b0;
    end
    // R12 slave engine
    if (!smbus_reg) begin
      state_next = S_IDLE;
      oe_next = 1'b0;
    end else if (startCond) begin
      state_next = S_RECV;
      kind_next = K_ADDR;
      bitCnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stopCond) begin
      state_next = S_IDLE;
      cmdSeen_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
        end
        S_RECV: begin
          if (sclRise && bitCnt_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], syncB[1]};
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == 4'h8) begin
            acked_next = 1'b0;
            unique case (kind_reg)
              // R13 R15 R16 address match
              K_ADDR: begin
                if (addrHit[2]) begin
                  acked_next = shift_reg[0] ? cmdSeen_reg : 1'b1;
                  base_next = addrHit[1:0];
                  isRd_next = shift_reg[0];
                end
              end
              K_CMD: begin
                acked_next = 1'b1;
                ptr_next = {base_reg, shift_reg};
                cmdSeen_next = 1'b1;
              end
              // R13 count check
              K_CNT: begin
                acked_next = (shift_reg != 8'h00) && (shift_reg <= `HPM_BLK_MAX);
                cnt_next = shift_reg;
                idx_next = 8'h00;
              end
              default: begin
                acked_next = idx_reg < cnt_reg;
                if (idx_reg < cnt_reg) begin
                  wrEn = ptr_reg <= `HPM_RANGE_END;
                  // R20 address step
                  ptr_next = {ptr_reg[9:8], ptr_reg[7:0] + 8'h01};
                  idx_next = idx_reg + 8'h01;
                end
              end
            endcase
            oe_next = acked_next;
            state_next = S_ACK;
            bitCnt_next = 4'h0;
          end
        end
        S_ACK: begin
          if (sclFall) begin
            oe_next = 1'b0;
            if (!acked_reg) begin
              state_next = S_IDLE;
            end else if (isRd_reg) begin
              tx_next = `HPM_BLK_READ_LEN;
              oe_next = ~tx_next[7];
              state_next = S_SEND;
            end else begin
              state_next = S_RECV;
              kind_next = (kind_reg == K_ADDR) ? K_CMD : (kind_reg == K_CMD) ? K_CNT : K_DATA;
            end
          end
        end
        S_SEND: begin
          if (sclRise) bitCnt_next = bitCnt_reg + 4'h1;
          if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              oe_next = 1'b0;
              state_next = S_MACK;
            end else if (bitCnt_reg == 4'h0) begin
              oe_next = ~tx_reg[7];
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              oe_next = ~tx_reg[6];
            end
          end
        end
        S_MACK: begin
          if (sclRise) begin
            bitCnt_next = 4'h0;
            state_next = syncB[1] ? S_IDLE : S_SEND;
            tx_next = rdData;
            ptr_next = {ptr_reg[9:8], ptr_reg[7:0] + 8'h01};
          end
        end
        default: state_next = S_IDLE;
      endcase
    end
    // Writes that land on the mask and status bytes.
    if (wrEn) begin
      if (ptr_reg == `HPM_OFF_RMBL) rmbl_next = shift_reg[3:0];
      if (ptr_reg == `HPM_OFF_USED) used_next = shift_reg[3:0];
      if (ptr_reg == `HPM_OFF_LEGACY) leg_next = shift_reg[3:0];
      // R14 config done
      if (ptr_reg == `HPM_OFF_STATUS && !shift_reg[`HPM_CFG_ACT_BIT]) cfgAct_next = 1'b0;
    end
  end
  // Register the slave, strap and mask state.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;   kind_reg <= K_ADDR;  bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;    tx_reg <= 8'h00;     cnt_reg <= 8'h00;
      idx_reg <= 8'h00;      ptr_reg <= 10'h000;  base_reg <= 2'h0;
      isRd_reg <= 1'b0;      cmdSeen_reg <= 1'b0; acked_reg <= 1'b0;
      oe_reg <= 1'b0;        smbus_reg <= 1'b0;   cfgAct_reg <= 1'b1;
      strapCnt_reg <= 2'h0;  rmbl_reg <= `HPM_RST_RMBL;
      used_reg <= `HPM_RST_USED;
      leg_reg <= `HPM_RST_LEGACY;
    end else begin
      state_reg <= state_next;   kind_reg <= kind_next;   bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;   tx_reg <= tx_next;       cnt_reg <= cnt_next;
      idx_reg <= idx_next;       ptr_reg <= ptr_next;     base_reg <= base_next;
      isRd_reg <= isRd_next;     cmdSeen_reg <= cmdSeen_next;
      acked_reg <= acked_next;   oe_reg <= oe_next;       smbus_reg <= smbus_next;
      cfgAct_reg <= cfgAct_next; strapCnt_reg <= strapCnt_next;
      rmbl_reg <= rmbl_next;     used_reg <= used_next;   leg_reg <= leg_next;
    end
  end
  // Configuration byte storage; the mask bytes live in their own registers.
  always_ff @(posedge ref_clk) begin
    if (wrEn) mem[ptr_reg] <= shift_reg;
  end
  // ------------------------------------------------------------
  // Port mapping
  // ------------------------------------------------------------
  logic [2:0]  lp [4];
  logic [2:0]  extCnt, ssCnt;
  logic [5:0]  permComb;
  logic [11:0] mapComb;
  logic [3:0]  bothMask;
  // R1 R2 R5 R6 R7 consecutive numbering
  always_comb begin
    bothMask = used_reg & ~leg_reg;
    extCnt = 3'h0;
    for (int i = 0; i < 4; i++) begin
      lp[i] = 3'h0;
      if (bothMask[i]) begin
        extCnt = extCnt + 3'h1;
        lp[i] = extCnt;
      end
    end
    ssCnt = extCnt;
    for (int i = 0; i < 4; i++) begin
      if (leg_reg[i]) begin
        extCnt = extCnt + 3'h1;
        lp[i] = extCnt;
      end
    end
    permComb = 6'h00;
    mapComb = {lp[3], lp[2], lp[1], lp[0]};
    // R4 permanent attach
    for (int i = 0; i < 4; i++) begin
      if ((bothMask[i] | leg_reg[i]) && !rmbl_reg[i]) permComb[lp[i] - 3'h1] = 1'b1;
    end
    // R3 R18 internal ports
    permComb[extCnt] = 1'b1;
    permComb[extCnt + 3'h1] = 1'b1;
  end
  // ------------------------------------------------------------
  // Frozen report registers
  // ------------------------------------------------------------
  logic lockNow;
  assign lockNow = cfgAct_reg & ~cfgAct_next;
  // R19 snapshot at config done
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      upstreamConnectEn <= 1'b0;  port4NoGen1 <= 1'b0;     usb3PortCount <= 3'h0;
      usb2PortCount <= 3'h0;      hidPort <= 3'h0;         billboardPort <= 3'h0;
      logicalPortMap <= 12'h000;  usb3MemberMask <= 4'h0;  permAttachedMask <= 6'h00;
      serialDataOut <= 1'b0;      serialDataOe <= 1'b0;
    end else begin
      serialDataOut <= 1'b0;
      serialDataOe <= oe_next;
      if (lockNow) begin
        upstreamConnectEn <= 1'b1;
        // R8 R9 R10 R11 invalid combos
        port4NoGen1 <= invalidCombo(used_reg, leg_reg);
        usb3PortCount <= ssCnt;
        usb2PortCount <= extCnt + 3'h2;
        hidPort <= extCnt + 3'h1;
        billboardPort <= extCnt + 3'h2;
        logicalPortMap <= mapComb;
        usb3MemberMask <= bothMask;
        permAttachedMask <= permComb;
      end
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence cfgDone;
    $fell(cfgAct_reg);
  endsequence
  sequence fullPorts;
    $past(used_reg) == 4'hF && $past(leg_reg) == 4'h0;
  endsequence
  connectHold_a: assert property (cfgAct_reg |-> !upstreamConnectEn) // R14
    else $error("Upstream connect while configuration active.");
  connectRise_a: assert property (cfgDone |-> upstreamConnectEn) // R14
    else $error("Upstream connect missing after config done.");
  fullMap_a: assert property (cfgDone ##0 fullPorts |-> usb3PortCount == 3'h4 // R1
    && usb2PortCount == 3'h6 && logicalPortMap == 12'h8D1)
    else $error("Full port map wrong.");
  internalPorts_a: assert property (upstreamConnectEn |-> billboardPort == usb2PortCount // R18
    && hidPort == usb2PortCount - 3'h1 && permAttachedMask[billboardPort - 3'h1])
    else $error("Internal port numbering wrong.");
  gen1Block_a: assert property (cfgDone |-> port4NoGen1 == // R8
    invalidCombo($past(used_reg), $past(leg_reg)))
    else $error("Port 4 speed block wrong.");
  frozen_a: assert property (upstreamConnectEn && $past(upstreamConnectEn) |-> // R19
    $stable(logicalPortMap) && $stable(usb2PortCount))
    else $error("Report changed after lock.");
  addrAck_a: assert property (state_reg == S_RECV && kind_reg == K_ADDR && oe_next // R15
    |-> shift_reg[7:3] == 5'b10001 && shift_reg[2:1] != 2'b11)
    else $error("Acknowledged a foreign address.");
  ptrStep_a: assert property (wrEn |=> ptr_reg[7:0] == $past(ptr_reg[7:0]) + 8'h01 // R20
    && ptr_reg[9:8] == $past(ptr_reg[9:8]))
    else $error("Byte address did not step.");
  quietBus_a: assert property (!smbus_reg |=> !serialDataOe) // R17
    else $error("Serial data driven while interface off.");
endmodule

// file: hpm_consts.svh
// Offsets, address map, reset values and limits of the hub port-map configuration block.
`ifndef HPM_CONSTS_SVH
`define HPM_CONSTS_SVH
// ------------------------------------------------------------
// Register offsets and fields
// ------------------------------------------------------------
`define HPM_OFF_RMBL      10'h007
`define HPM_OFF_USED      10'h008
`define HPM_OFF_LEGACY    10'h026
`define HPM_OFF_STATUS    10'h0F8
`define HPM_CFG_ACT_BIT   0
`define HPM_RANGE_END     10'h2DF
`define HPM_MEM_DEPTH     736
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define HPM_RST_RMBL      4'hF
`define HPM_RST_USED      4'hF
`define HPM_RST_LEGACY    4'h0
// ------------------------------------------------------------
// Slave addresses and transfer limits
// ------------------------------------------------------------
`define HPM_SADDR_BASE0   7'h44
`define HPM_SADDR_BASE1   7'h45
`define HPM_SADDR_BASE2   7'h46
`define HPM_BLK_MAX       8'h20
`define HPM_BLK_READ_LEN  8'h20
`define HPM_STRAP_WAIT    2'h2
`endif

// file: hpm_pkg.sv
// Types shared by the hub port-map configuration block.
package hpm_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RECV = 5'b00010,
    S_ACK  = 5'b00100,
    S_SEND = 5'b01000,
    S_MACK = 5'b10000
  } hpm_state_e;
  typedef enum logic [3:0] {
    K_ADDR = 4'b0001,
    K_CMD  = 4'b0010,
    K_CNT  = 4'b0100,
    K_DATA = 4'b1000
  } hpm_kind_e;
endpackage

// file: hpm_smbus_host.sv
// Behavioural SMBus host that drives the configuration slave's serial pins.
`timescale 1ns/100ps
module hpm_smbus_host (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPullLow
);
  // lines idle high
  // The clock starts driven high and the data line released, so both lines sit high at reset.
  initial begin
    sclOut = 1'b1;
    sdaPullLow = 1'b0;
  end

  // Waits a number of falling clock edges.
  task automatic q(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Pulls the data line low or lets it go, used around a reset release.
  task automatic hold_data(input logic v);
    sdaPullLow = v;
  endtask

  // Start or repeated start; the long first wait lets an acknowledge end first.
  task automatic bus_start();
    sdaPullLow = 1'b0;
    q(8);
    sclOut = 1'b1;
    q(4);
    sdaPullLow = 1'b1;
    q(4);
    sclOut = 1'b0;
    q(2);
  endtask

  // Stop condition; the clock then stands high until the next frame.
  task automatic bus_stop();
    sdaPullLow = 1'b1;
    q(4);
    sclOut = 1'b1;
    q(4);
    sdaPullLow = 1'b0;
    q(8);
  endtask

  // One 160 ns bit slot; data moves only while the clock is low.
  task automatic clk_bit(input logic b, output logic seen);
    sdaPullLow = !b;
    q(6);
    sclOut = 1'b1;
    q(4);
    seen = sdaLine;
    q(4);
    sclOut = 1'b0;
    q(2);
  endtask

  // block protocol bytes
  // Sends a byte most significant bit first and reports the acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  // Receives a byte, then acknowledges it or not.
  task automatic get_byte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(!ackIt, s);
  endtask
endmodule

// file: hpm_config_test.sv
// Self-checking bench for the hub port-map configuration slave.
`timescale 1ns/100ps
`include "hpm_consts.svh"
module hpm_config_test import hpm_pkg::*; ;
  localparam int LIMIT = 80000;
  logic        ref_clk;
  logic        nrst;
  logic        strap;
  logic        sclW;
  logic        sdaPull;
  logic        sdaOut;
  logic        sdaOe;
  logic        connEn;
  logic        noGen1;
  logic [2:0]  u3Cnt;
  logic [2:0]  u2Cnt;
  logic [2:0]  hidNum;
  logic [2:0]  bbNum;
  logic [11:0] pMap;
  logic [3:0]  memMask;
  logic [5:0]  permMask;
  wire         sdaLine;
  int          failCount = 0;
  int          nTests = 0;
  int          cycles = 0;

  // Open-drain data wire with a pull-up; either party may pull it low.
  assign sdaLine = !(sdaPull || sdaOe);

  hpm_smbus_host host_u (
    .ref_clk   (ref_clk),
    .sdaLine   (sdaLine),
    .sclOut    (sclW),
    .sdaPullLow(sdaPull)
  );

  hpm_config dut_u (
    .ref_clk          (ref_clk),
    .nrst             (nrst),
    .serialClockIn    (sclW),
    .serialDataIn     (sdaLine),
    .hostIfModeStrap  (strap),
    .serialDataOut    (sdaOut),
    .serialDataOe     (sdaOe),
    .upstreamConnectEn(connEn),
    .port4NoGen1      (noGen1),
    .usb3PortCount    (u3Cnt),
    .usb2PortCount    (u2Cnt),
    .hidPort          (hidNum),
    .billboardPort    (bbNum),
    .logicalPortMap   (pMap),
    .usb3MemberMask   (memMask),
    .permAttachedMask (permMask)
  );

  // Clock and a hang guard that ends the run as a failure.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failCount++;
      endOfTest();
    end
  end

  // Prints the verdict and stops.
  task automatic endOfTest();
    if (failCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
      failCount++;
    end
  endtask

  // Resets for two cycles with a chosen strap and data-line level.
  task automatic do_reset(input logic s, input logic low);
    nrst = 1'b0;
    strap = s;
    host_u.hold_data(low);
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
    host_u.hold_data(1'b0);
    repeat (10) @(negedge ref_clk);
  endtask

  // Block write of one or two data bytes; ok when every byte was acknowledged.
  task automatic wr_block(input logic [6:0] sa, input logic [7:0] cmd, input logic [7:0] n,
                          input logic [15:0] d, output logic ok);
    logic [4:0] a;
    a[4] = 1'b1;
    host_u.bus_start();
    host_u.put_byte({sa, 1'b0}, a[0]);
    host_u.put_byte(cmd, a[1]);
    host_u.put_byte(n, a[2]);
    host_u.put_byte(d[7:0], a[3]);
    if (n == 8'h02) begin
      host_u.put_byte(d[15:8], a[4]);
    end
    host_u.bus_stop();
    ok = &a;
  endtask

  // Block read of the count byte and two data bytes.
  task automatic rd_block(input logic [6:0] sa, input logic [7:0] cmd, output logic [7:0] cnt,
                          output logic [15:0] d, output logic ok);
    logic [2:0] a;
    host_u.bus_start();
    host_u.put_byte({sa, 1'b0}, a[0]);
    host_u.put_byte(cmd, a[1]);
    host_u.bus_start();
    host_u.put_byte({sa, 1'b1}, a[2]);
    host_u.get_byte(1'b1, cnt);
    host_u.get_byte(1'b1, d[7:0]);
    host_u.get_byte(1'b0, d[15:8]);
    host_u.bus_stop();
    ok = &a;
  endtask

  // no timeout
  // The hub stays disconnected and unreported while configuration is open.
  task automatic t_wait();
    do_reset(1'b0, 1'b0);
    repeat (3000) @(negedge ref_clk);
    chk("upstreamConnectEn", 16'h0000, 16'(connEn));
    chk("usb2PortCount", 16'h0000, 16'(u2Cnt));
  endtask

  // unsupported access
  // Foreign address, read without command and bad counts get no acknowledge.
  task automatic t_refuse();
    logic a;
    logic b;
    logic c;
    host_u.bus_start();
    host_u.put_byte({7'h47, 1'b0}, a);
    host_u.bus_stop();
    chk("ackForeignAddr", 16'h0000, 16'(a));
    host_u.bus_start();
    host_u.put_byte({`HPM_SADDR_BASE0, 1'b1}, a);
    host_u.bus_stop();
    chk("ackReadNoCmd", 16'h0000, 16'(a));
    for (int k = 0; k < 2; k++) begin
      host_u.bus_start();
      host_u.put_byte({`HPM_SADDR_BASE0, 1'b0}, a);
      host_u.put_byte(8'(`HPM_OFF_USED), b);
      host_u.put_byte(k == 0 ? 8'h00 : 8'h21, c);
      host_u.bus_stop();
      chk("ackBadCount", 16'h0006, 16'({a, b, c}));
    end
  endtask

  // address windows
  // Each slave address holds its own bytes, up to the last string byte.
  task automatic t_ranges();
    logic [7:0]  cnt;
    logic [15:0] d;
    logic        ok;
    for (int k = 0; k < 3; k++) begin
      wr_block(`HPM_SADDR_BASE0 + 7'(k), 8'hDE, 8'h02, 16'hC030 + 16'h0101 * 16'(k), ok);
      chk("ackWrite", 16'h0001, 16'(ok));
    end
    for (int k = 0; k < 3; k++) begin
      rd_block(`HPM_SADDR_BASE0 + 7'(k), 8'hDE, cnt, d, ok);
      chk("ackRead", 16'h0001, 16'(ok));
      chk("readCount", 16'(`HPM_BLK_READ_LEN), 16'(cnt));
      chk("readData", 16'hC030 + 16'h0101 * 16'(k), d);
    end
    chk("serialDataOut", 16'h0000, 16'(sdaOut));
  endtask

  // interface enable
  // EEPROM strap or a low data line at reset leaves defaults and connects.
  task automatic t_strap();
    for (int k = 0; k < 2; k++) begin
      do_reset(k == 0, k == 1);
      chk("upstreamConnectEn", 16'h0001, 16'(connEn));
      chk("usb2PortCount", 16'h0006, 16'(u2Cnt));
    end
  endtask

  // port numbering
  // Masks are programmed, the lock taken, the used mask changed, then all reports judged.
  task automatic t_maps();
    logic [11:0] tab [14] = '{12'hFF0, 12'hEF0, 12'hC70, 12'h3F2, 12'h8F2, 12'hFFE, 12'hAF0,
                              12'hAF5, 12'hBF1, 12'hBF5, 12'hEF4, 12'hFF5, 12'hBF0, 12'h5A0};
    logic [3:0]  used;
    logic [3:0]  rmbl;
    logic [3:0]  leg;
    logic [3:0]  ok;
    logic [11:0] map;
    logic [5:0]  perm;
    logic        bad;
    int          n;
    int          i;
    for (int k = 0; k < 14; k++) begin
      {used, rmbl, leg} = tab[k];
      do_reset(1'b0, 1'b0);
      wr_block(`HPM_SADDR_BASE0, 8'(`HPM_OFF_RMBL), 8'h02, {4'h0, used, 4'h0, rmbl}, ok[0]);
      wr_block(`HPM_SADDR_BASE0, 8'(`HPM_OFF_LEGACY), 8'h01, {12'h000, leg}, ok[1]);
      chk("upstreamConnectEn", 16'h0000, 16'(connEn));
      wr_block(`HPM_SADDR_BASE0, 8'(`HPM_OFF_STATUS), 8'h01, 16'h0000, ok[2]);
      wr_block(`HPM_SADDR_BASE0, 8'(`HPM_OFF_USED), 8'h01, 16'h0000, ok[3]);
      chk("ackConfig", 16'h000F, 16'(ok));
      chk("upstreamConnectEn", 16'h0001, 16'(connEn));
      n = 0;
      map = 12'h000;
      perm = 6'h00;
      for (int p = 0; p < 8; p++) begin
        i = p % 4;
        if (p < 4 ? (used[i] && !leg[i]) : leg[i]) begin
          n++;
          map[3*i +: 3] = 3'(n);
          perm[n-1] = used[i] && !rmbl[i];
        end
      end
      perm[n] = 1'b1;
      perm[n+1] = 1'b1;
      bad = (used == 4'hA && !leg[3] && !leg[1]) || (used == 4'hB && leg == 4'h1)
         || (used == 4'hB && leg == 4'h5) || (used == 4'hE && leg[3:1] == 3'b010)
         || (used == 4'hF && leg == 4'h5);
      chk("usb3PortCount", 16'($countones(used & ~leg)), 16'(u3Cnt));
      chk("usb2PortCount", 16'(n + 2), 16'(u2Cnt));
      chk("hidPort", 16'(n + 1), 16'(hidNum));
      chk("billboardPort", 16'(n + 2), 16'(bbNum));
      chk("logicalPortMap", 16'(map), 16'(pMap));
      chk("usb3MemberMask", 16'(used & ~leg), 16'(memMask));
      chk("permAttachedMask", 16'(perm), 16'(permMask));
      chk("port4NoGen1", 16'(bad), 16'(noGen1));
    end
  endtask

  // Main sequence.
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    strap = 1'b0;
    t_wait();
    t_refuse();
    t_ranges();
    t_strap();
    t_maps();
    endOfTest();
  end
endmodule
